// >>> lpd_cfg_map.svh
`ifndef LPD_CFG_MAP_SVH
`define LPD_CFG_MAP_SVH

// Register indices as printed; byte address is four times the index
`define LPD_IDX_TONE_GEN     8'h1F
`define LPD_IDX_DET_CLK      8'h20
`define LPD_IDX_LIMITER      8'h23
`define LPD_IDX_GAIN_COMP    8'h24

// Reset values
`define LPD_RST_TONE_GEN     8'h80
`define LPD_RST_DET_CLK      8'h00
`define LPD_RST_LIMITER      8'h00
`define LPD_RST_GAIN_COMP    8'h00

// Writable bit masks; every other bit is reserved
`define LPD_WMASK_TONE_GEN   8'hC0
`define LPD_WMASK_DET_CLK    8'hF4
`define LPD_WMASK_LIMITER    8'hF0
`define LPD_WMASK_GAIN_COMP  8'hFF

// Field positions
`define LPD_POS_HI_SEL       6
`define LPD_POS_EXT_FREQ     4
`define LPD_POS_PH1_EN       2
`define LPD_POS_LIM_OUT      4
`define LPD_POS_AGC          4
`define LPD_POS_DRC          0

`endif

// >>> lpd_pkg.sv
package lpd_pkg;

  typedef enum logic [1:0] {
    LPD_CLK_INT_OSC,
    LPD_CLK_BIT_CLK,
    LPD_CLK_CTRL_CLK,
    LPD_CLK_CUSTOM
  } lpd_clk_src_t;

  typedef enum logic [1:0] {
    LPD_LIM_IN_MAX,
    LPD_LIM_IN_CH1,
    LPD_LIM_IN_CH0,
    LPD_LIM_IN_AVG
  } lpd_lim_in_t;

  typedef struct packed {
    logic [7:0] tone_gen;
    logic [7:0] det_clk;
    logic [7:0] limiter;
    logic [7:0] gain_comp;
  } lpd_regs_t;

endpackage

// >>> lpd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpd_cfg_map.svh"

// Turns the stored fields into one-hot selects and enables
module lpd_decode
  import lpd_pkg::*;
(
  input  wire logic [7:0] tone_gen,
  input  wire logic [7:0] det_clk,
  input  wire logic [7:0] limiter,
  input  wire logic [7:0] gain_comp,
  output logic      [3:0] tone_ch_onehot,
  output logic      [3:0] clk_src_onehot,
  output logic      [3:0] lim_in_onehot,
  output logic      [1:0] lim_out_apply,
  output logic      [3:0] agc_en,
  output logic      [3:0] drc_en
);
  logic [1:0] lim_out;

  assign lim_out = limiter[`LPD_POS_LIM_OUT +: 2];

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      // Code n routes to channel n+1
      assign tone_ch_onehot[i] = (tone_gen[`LPD_POS_HI_SEL +: 2] == 2'(i));
      assign clk_src_onehot[i] = (det_clk[`LPD_POS_HI_SEL +: 2] == 2'(i));
      assign lim_in_onehot[i]  = (limiter[`LPD_POS_HI_SEL +: 2] == 2'(i));
      // Channel 1 sits at the high bit of each nibble
      assign agc_en[i] = gain_comp[`LPD_POS_AGC + 3 - i];
      assign drc_en[i] = gain_comp[`LPD_POS_DRC + 3 - i];
    end
  endgenerate

  // Bit 0 is playback channel zero, bit 1 channel one
  assign lim_out_apply[0] = (lim_out == 2'h0) || (lim_out == 2'h2);
  assign lim_out_apply[1] = (lim_out == 2'h0) || (lim_out == 2'h1);

endmodule
`default_nettype wire

// >>> lpd_cfg_regs.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lpd_cfg_map.svh"

// Notes on behaviour
// - Tone channel select bits 7-6, reset 10b
// - Reserved bits read zero; writes ignored
// - Detect clock source select at bits 7-6
// - External clock frequency code; 1 reserved
// - Bit 2 enables phase-one comparator detection
// - Limiter detector source select, bits 7-6
// - Limiter gain applied channels, bits 5-4
// - Bits 7-4 enable auto gain ch1-4
// - Bits 3-0 enable range compression ch1-4
module lpd_cfg_regs
  import lpd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  tone_gen_channel_select,
  output logic      [3:0]  detect_clock_source_select,
  output logic      [1:0]  detect_ext_clock_freq,
  output logic             detect_ext_clock_reserved,
  output logic             phase_one_detect_enable,
  output logic      [3:0]  limiter_source_select,
  output logic      [1:0]  limiter_apply_channels,
  output logic      [3:0]  auto_gain_enable,
  output logic      [3:0]  range_compress_enable
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    lpd_regs_t   regs;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic [3:0]  tone_sel;
    logic [3:0]  clk_sel;
    logic [1:0]  ext_freq;
    logic        ext_rsvd;
    logic        ph1_en;
    logic [3:0]  lim_in;
    logic [1:0]  lim_out;
    logic [3:0]  agc;
    logic [3:0]  drc;
  } lpd_state_t;

  lpd_state_t s_q;
  lpd_state_t s_d;
  lpd_regs_t  nregs;

  logic [3:0] dec_tone;
  logic [3:0] dec_clk;
  logic [3:0] dec_lim_in;
  logic [1:0] dec_lim_out;
  logic [3:0] dec_agc;
  logic [3:0] dec_drc;

  logic       setup;
  logic       wr_fire;
  logic       hit_tone;
  logic       hit_clk;
  logic       hit_lim;
  logic       hit_gain;
  logic       mapped;
  logic [7:0] rd_byte;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Slave answers in the cycle after setup, so every access is exactly two cycles
  assign setup    = psel && !penable;
  // Write lands only at the access edge where the master sees pready high
  assign wr_fire  = psel && penable && s_q.ready && pwrite && pstrb[0];
  assign hit_tone = (paddr == {2'h0, `LPD_IDX_TONE_GEN, 2'h0});
  assign hit_clk  = (paddr == {2'h0, `LPD_IDX_DET_CLK, 2'h0});
  assign hit_lim  = (paddr == {2'h0, `LPD_IDX_LIMITER, 2'h0});
  assign hit_gain = (paddr == {2'h0, `LPD_IDX_GAIN_COMP, 2'h0});
  assign mapped   = hit_tone || hit_clk || hit_lim || hit_gain;

  // ----------------------------------------
  // Decoder
  // ----------------------------------------
  // Decodes the next value so outputs follow a write with no extra lag
  lpd_decode u_decode (
    .tone_gen       (nregs.tone_gen),
    .det_clk        (nregs.det_clk),
    .limiter        (nregs.limiter),
    .gain_comp      (nregs.gain_comp),
    .tone_ch_onehot (dec_tone),
    .clk_src_onehot (dec_clk),
    .lim_in_onehot  (dec_lim_in),
    .lim_out_apply  (dec_lim_out),
    .agc_en         (dec_agc),
    .drc_en         (dec_drc)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nregs = s_q.regs;
    rd_byte = 8'h00;
    // Masking keeps reserved bits at zero whatever software writes
    if (wr_fire && hit_tone) begin
      nregs.tone_gen = pwdata[7:0] & `LPD_WMASK_TONE_GEN;
    end
    if (wr_fire && hit_clk) begin
      nregs.det_clk = pwdata[7:0] & `LPD_WMASK_DET_CLK;
    end
    if (wr_fire && hit_lim) begin
      nregs.limiter = pwdata[7:0] & `LPD_WMASK_LIMITER;
    end
    if (wr_fire && hit_gain) begin
      nregs.gain_comp = pwdata[7:0] & `LPD_WMASK_GAIN_COMP;
    end
    if (hit_tone) begin
      rd_byte = s_q.regs.tone_gen;
    end else if (hit_clk) begin
      rd_byte = s_q.regs.det_clk;
    end else if (hit_lim) begin
      rd_byte = s_q.regs.limiter;
    end else if (hit_gain) begin
      rd_byte = s_q.regs.gain_comp;
    end

    s_d = s_q;
    s_d.regs = nregs;
    s_d.ready = setup;
    s_d.slverr = setup && !mapped;
    if (setup && !pwrite) begin
      s_d.rdata = {24'h000000, rd_byte};
    end
    s_d.tone_sel = dec_tone;
    s_d.clk_sel  = dec_clk;
    s_d.ext_freq = nregs.det_clk[`LPD_POS_EXT_FREQ +: 2];
    // Flags the reserved frequency code so the clock logic can refuse it
    s_d.ext_rsvd = (nregs.det_clk[`LPD_POS_EXT_FREQ +: 2] == 2'h1);
    s_d.ph1_en   = nregs.det_clk[`LPD_POS_PH1_EN];
    s_d.lim_in   = dec_lim_in;
    s_d.lim_out  = dec_lim_out;
    s_d.agc      = dec_agc;
    s_d.drc      = dec_drc;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.regs.tone_gen  <= `LPD_RST_TONE_GEN;
      s_q.regs.det_clk   <= `LPD_RST_DET_CLK;
      s_q.regs.limiter   <= `LPD_RST_LIMITER;
      s_q.regs.gain_comp <= `LPD_RST_GAIN_COMP;
      s_q.tone_sel       <= 4'h4;
      s_q.clk_sel        <= 4'h1;
      s_q.lim_in         <= 4'h1;
      s_q.lim_out        <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata                     = s_q.rdata;
  assign pready                     = s_q.ready;
  assign pslverr                    = s_q.slverr;
  assign tone_gen_channel_select    = s_q.tone_sel;
  assign detect_clock_source_select = s_q.clk_sel;
  assign detect_ext_clock_freq      = s_q.ext_freq;
  assign detect_ext_clock_reserved  = s_q.ext_rsvd;
  assign phase_one_detect_enable    = s_q.ph1_en;
  assign limiter_source_select      = s_q.lim_in;
  assign limiter_apply_channels     = s_q.lim_out;
  assign auto_gain_enable           = s_q.agc;
  assign range_compress_enable      = s_q.drc;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_TONE_RESET: assert property (@(posedge pclk) $rose(presetn) |->
    tone_gen_channel_select == 4'h4) else $error("tone select not channel 3 after reset");
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && hit_tone |-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h0)
    else $error("reserved bits read nonzero");
  AST_CLK_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_clk |=> detect_clock_source_select == (4'h1 << $past(pwdata[7:6])))
    else $error("clock source select wrong");
  AST_EXT_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    detect_ext_clock_reserved == (detect_ext_clock_freq == 2'h1))
    else $error("reserved frequency flag wrong");
  AST_PH1: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_clk |=> phase_one_detect_enable == $past(pwdata[2]))
    else $error("phase one enable wrong");
  AST_LIM_IN: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_lim |=> limiter_source_select == (4'h1 << $past(pwdata[7:6])))
    else $error("limiter source wrong");
  AST_LIM_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_lim && pwdata[5:4] == 2'h3 |=> limiter_apply_channels == 2'h0)
    else $error("limiter applied with code 3");
  AST_AGC: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_gain |=> auto_gain_enable[0] == $past(pwdata[7]))
    else $error("auto gain ch1 wrong");
  AST_DRC: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && hit_gain |=> range_compress_enable[3] == $past(pwdata[0]))
    else $error("compression ch4 wrong");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_fire && hit_gain) |=> $stable(auto_gain_enable))
    else $error("gain enables changed without write");

endmodule
`default_nettype wire

// >>> test_lowpower_detect_limiter_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpd_cfg_map.svh"

module test_lowpower_detect_limiter_cfg_regs;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  tone_sel, clk_sel, lim_sel, agc, drc;
  logic [1:0]  ext_freq, lim_apply;
  logic        ext_resv, ph1_en;
  logic [33:0] exp_q[$];
  logic [33:0] cur;
  logic [7:0]  model[4];
  logic [11:0] addr[4]  = '{12'({`LPD_IDX_TONE_GEN, 2'h0}), 12'({`LPD_IDX_DET_CLK, 2'h0}),
                            12'({`LPD_IDX_LIMITER, 2'h0}), 12'({`LPD_IDX_GAIN_COMP, 2'h0})};
  logic [7:0]  wmask[4] = '{`LPD_WMASK_TONE_GEN, `LPD_WMASK_DET_CLK,
                            `LPD_WMASK_LIMITER, `LPD_WMASK_GAIN_COMP};
  logic [7:0]  rstv[4]  = '{`LPD_RST_TONE_GEN, `LPD_RST_DET_CLK,
                            `LPD_RST_LIMITER, `LPD_RST_GAIN_COMP};
  logic [31:0] rng      = 32'h00009610;
  logic [7:0]  d;
  int          err_count       = 0;
  int          samples_checked = 0;

  always #50 pclk = ~pclk;

  lpd_cfg_regs i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tone_gen_channel_select(tone_sel),
    .detect_clock_source_select(clk_sel), .detect_ext_clock_freq(ext_freq),
    .detect_ext_clock_reserved(ext_resv), .phase_one_detect_enable(ph1_en),
    .limiter_source_select(lim_sel), .limiter_apply_channels(lim_apply),
    .auto_gain_enable(agc), .range_compress_enable(drc)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Decoded outputs as the stored fields should drive them
  function automatic logic [31:0] dec_exp();
    logic [7:0] t, c, l, g;
    t = model[0];
    c = model[1];
    l = model[2];
    g = model[3];
    return {6'h00, 4'h1 << t[7:6], 4'h1 << c[7:6], c[5:4], c[5:4] == 2'h1, c[2],
            4'h1 << l[7:6], ~l[5:4], g[4], g[5], g[6], g[7], g[0], g[1], g[2], g[3]};
  endfunction

  function automatic logic [31:0] dec_seen();
    return {6'h00, tone_sel, clk_sel, ext_freq, ext_resv, ph1_en, lim_sel, lim_apply, agc, drc};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                     input logic st, input logic [7:0] exp, input logic err);
    int          n;
    logic [31:0] r;
    n = 0;
    r = xs();
    @(posedge pclk);
    exp_q.push_back({~wr, err, 24'h000000, exp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {r[31:8], wd};
    pstrb   <= {r[3:1], st};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] wd, input logic st);
    if (st) model[i] = wd & wmask[i];
    apb(1'b1, addr[i], wd, st, 8'h00, 1'b0);
    // Outputs settle after the completing edge
    @(negedge pclk);
    chk("decoded", dec_seen(), dec_exp());
  endtask

  task automatic rd(input int i);
    apb(1'b0, addr[i], 8'h00, 1'b1, model[i], 1'b0);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) model[i] = rstv[i];
    chk("reset outputs", dec_seen(), dec_exp());
    for (int i = 0; i < 4; i++) rd(i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Response monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unasked response", 32'h1, 32'h0);
      end else begin
        cur = exp_q.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, cur[32]});
        if (cur[33]) chk("prdata", prdata, {24'h000000, cur[7:0]});
      end
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    do_reset();
    // Every code of each two-bit field except frequency code 1, reserved bits masked to zero before the write
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) begin
        d = 8'(xs());
        if (k < 4) d[7:4] = {2'(k), 2'(k)};
        d = d & wmask[i];
        if (i == 1 && d[5:4] == 2'h1) d[5:4] = 2'h2;
        wr(i, d, 1'b1);
        rd(i);
      end
    end
    wr(2, ~model[2] & wmask[2], 1'b0);
    rd(2);
    apb(1'b1, 12'h084, 8'h5A, 1'b1, 8'h00, 1'b1);
    apb(1'b0, 12'h084, 8'h00, 1'b1, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) rd(i);
    // Mid-run reset must restore every field
    do_reset();
    summarize();
  end

  initial begin
    #(5000 * 100);
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
